// file: logic/boi_barrier_port.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Read channel stalls until both barrier halves are answered
// - Absorb 256 write barriers, writes keep flowing
// - Read barrier may stall read address channel
// - Overlapping traffic always takes one path
// - Barrier pairs leave in one order, unmixed
// - Every coherent slave port meets acceptance duties
// - Barrier never overtakes barrier-respecting traffic
// - Barrier covers everything observed before it
// - Non-barrier traffic may pass unanswered barrier
// - Hold read barrier: pair, snoops, writes
// - Device hazard check spans whole peripheral
// - Unknown peripheral range orders all accesses
// - Snoop answer only after write observed
// - Observation point is snoop response handshake
module boi_barrier_port
    import boi_pkg::*;
#(
    parameter int unsigned ID_W = 4,
    parameter int unsigned ADDR_W = 32,
    parameter int unsigned DATA_W = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    // Upstream read address
    input wire logic s_ar_valid,
    output logic s_ar_ready,
    input wire logic [ID_W-1:0] s_ar_id,
    input wire logic [ADDR_W-1:0] s_ar_addr,
    input wire logic s_ar_bar,
    // Upstream write address
    input wire logic s_aw_valid,
    output logic s_aw_ready,
    input wire logic [ID_W-1:0] s_aw_id,
    input wire logic [ADDR_W-1:0] s_aw_addr,
    input wire logic s_aw_bar,
    // Upstream read data
    output logic s_r_valid,
    input wire logic s_r_ready,
    output logic [ID_W-1:0] s_r_id,
    output logic [DATA_W-1:0] s_r_data,
    output logic s_r_last,
    // Upstream write response
    output logic s_b_valid,
    input wire logic s_b_ready,
    output logic [ID_W-1:0] s_b_id,
    // Downstream read address
    output logic m_ar_valid,
    input wire logic m_ar_ready,
    output logic [ID_W-1:0] m_ar_id,
    output logic [ADDR_W-1:0] m_ar_addr,
    // Downstream write address
    output logic m_aw_valid,
    input wire logic m_aw_ready,
    output logic [ID_W-1:0] m_aw_id,
    output logic [ADDR_W-1:0] m_aw_addr,
    // Downstream read data
    input wire logic m_r_valid,
    output logic m_r_ready,
    input wire logic [ID_W-1:0] m_r_id,
    input wire logic [DATA_W-1:0] m_r_data,
    input wire logic m_r_last,
    // Downstream write response
    input wire logic m_b_valid,
    output logic m_b_ready,
    input wire logic [ID_W-1:0] m_b_id,
    // Snoop traffic seen by the fabric
    input wire logic snp_issue,
    input wire logic cr_valid,
    output logic cr_ready,
    // Barrier engine busy
    output logic bar_busy
);
    boi_state_t state_reg; // Barrier engine state
    logic [ID_W-1:0] rbar_id_reg; // ID of the held read barrier
    logic [ID_W-1:0] wbar_mem [BOI_BAR_MAX]; // Queued write barrier IDs
    logic [BOI_PTR_W-1:0] wq_wr_reg, wq_rd_reg; // Queue write and read pointers
    logic [BOI_PTR_W:0] wq_cnt_reg; // Queued write barriers
    logic [BOI_CNT_W-1:0] rd_out_reg, wr_out_reg; // Reads and writes outstanding downstream
    logic [BOI_CNT_W-1:0] snp_out_reg; // Snoops awaiting response
    logic [BOI_CNT_W-1:0] pre_rd_reg, pre_wr_reg, pre_snp_reg; // Pre-barrier work left
    logic r_done_reg, b_done_reg; // Barrier read and write responses sent
    logic m_ar_valid_reg, m_aw_valid_reg; // Downstream address slices full
    logic s_r_valid_reg, s_b_valid_reg; // Upstream answer slots full
    logic ar_take, aw_take; // Upstream address handshakes
    logic ar_fwd_ok, aw_fwd_ok; // Address slices can accept
    logic rd_sent, wr_sent; // Downstream address handshakes
    logic rd_done, wr_done; // Last read beat and write response returned
    logic snp_done; // Snoop response handshake
    logic r_ins, b_ins; // Insert barrier read and write responses
    logic r_load, b_load; // Upstream answer slots load
    logic drained; // All pre-barrier obligations met

    // Handshake terms
    always_comb begin
        ar_fwd_ok = !m_ar_valid_reg || m_ar_ready;
        aw_fwd_ok = !m_aw_valid_reg || m_aw_ready;
        // Barrier halts reads until the engine is free
        s_ar_ready = (state_reg == BOI_ST_IDLE) && (s_ar_bar || ar_fwd_ok);
        // Write barriers queue; writes never wait on a barrier
        s_aw_ready = s_aw_bar ? (wq_cnt_reg < (BOI_PTR_W+1)'(BOI_BAR_MAX))
            : aw_fwd_ok;
        ar_take = s_ar_valid && s_ar_ready;
        aw_take = s_aw_valid && s_aw_ready;
        rd_sent = m_ar_valid_reg && m_ar_ready;
        wr_sent = m_aw_valid_reg && m_aw_ready;
        rd_done = m_r_valid && m_r_ready && m_r_last;
        wr_done = m_b_valid && m_b_ready;
        cr_ready = 1'b1;
        snp_done = cr_valid;
        r_ins = (state_reg == BOI_ST_RESP) && !r_done_reg && (!s_r_valid_reg || s_r_ready);
        b_ins = (state_reg == BOI_ST_RESP) && !b_done_reg && (!s_b_valid_reg || s_b_ready);
        // Barrier responses take priority over pass-through answers
        m_r_ready = (!s_r_valid_reg || s_r_ready) && !r_ins;
        m_b_ready = (!s_b_valid_reg || s_b_ready) && !b_ins;
        r_load = r_ins || (m_r_valid && m_r_ready);
        b_load = b_ins || (m_b_valid && m_b_ready);
        drained = (pre_rd_reg == BOI_CNT_RST) && (pre_wr_reg == BOI_CNT_RST)
            && (pre_snp_reg == BOI_CNT_RST);
        bar_busy = (state_reg != BOI_ST_IDLE);
        m_ar_valid = m_ar_valid_reg; // Registered outputs, one instance per coherent port
        m_aw_valid = m_aw_valid_reg;
        s_r_valid = s_r_valid_reg;
        s_b_valid = s_b_valid_reg;
    end

    // Downstream read address slice, the only read path
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            m_ar_valid_reg <= 1'b0;
            m_ar_id <= '0;
            m_ar_addr <= '0;
        end else if (ar_take && !s_ar_bar) begin
            m_ar_valid_reg <= 1'b1;
            m_ar_id <= s_ar_id;
            m_ar_addr <= s_ar_addr;
        end else if (m_ar_ready) begin
            m_ar_valid_reg <= 1'b0;
        end
    end

    // Downstream write address slice, the only write path
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            m_aw_valid_reg <= 1'b0;
            m_aw_id <= '0;
            m_aw_addr <= '0;
        end else if (aw_take && !s_aw_bar) begin
            m_aw_valid_reg <= 1'b1;
            m_aw_id <= s_aw_id;
            m_aw_addr <= s_aw_addr;
        end else if (m_aw_ready) begin
            m_aw_valid_reg <= 1'b0;
        end
    end

    // Write barrier queue in arrival order, pointers and fill count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wq_wr_reg <= '0;
            wq_rd_reg <= '0;
            wq_cnt_reg <= '0;
        end else begin
            if (aw_take && s_aw_bar) begin
                wbar_mem[wq_wr_reg] <= s_aw_id;
                wq_wr_reg <= wq_wr_reg + 1'b1;
            end
            // Oldest write half pairs with the held read half
            if (b_ins) begin
                wq_rd_reg <= wq_rd_reg + 1'b1;
            end
            wq_cnt_reg <= wq_cnt_reg + (BOI_PTR_W+1)'(aw_take && s_aw_bar)
                - (BOI_PTR_W+1)'(b_ins);
        end
    end

    // Outstanding traffic and snoop counters
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_out_reg <= BOI_CNT_RST;
            wr_out_reg <= BOI_CNT_RST;
            snp_out_reg <= BOI_CNT_RST;
        end else begin
            rd_out_reg <= rd_out_reg + BOI_CNT_W'(rd_sent) - BOI_CNT_W'(rd_done);
            wr_out_reg <= wr_out_reg + BOI_CNT_W'(wr_sent) - BOI_CNT_W'(wr_done);
            snp_out_reg <= snp_out_reg + BOI_CNT_W'(snp_issue) - BOI_CNT_W'(snp_done);
        end
    end

    // Barrier engine
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= BOI_ST_IDLE;
            rbar_id_reg <= '0;
            pre_rd_reg <= BOI_CNT_RST;
            pre_wr_reg <= BOI_CNT_RST;
            pre_snp_reg <= BOI_CNT_RST;
            r_done_reg <= 1'b0;
            b_done_reg <= 1'b0;
        end else begin
            case (state_reg)
                BOI_ST_IDLE: begin
                    // Take a read barrier and hold the read channel
                    if (ar_take && s_ar_bar) begin
                        rbar_id_reg <= s_ar_id;
                        state_reg <= BOI_ST_PAIR;
                    end
                end
                BOI_ST_PAIR: begin
                    // Write half present: freeze the pre-barrier set
                    if (wq_cnt_reg != '0) begin
                        // Every observed access counts, any address
                        // A completion on this very edge must not be waited for again
                        pre_rd_reg <= rd_out_reg + BOI_CNT_W'(m_ar_valid_reg)
                            - BOI_CNT_W'(rd_done);
                        pre_wr_reg <= wr_out_reg + BOI_CNT_W'(m_aw_valid_reg)
                            - BOI_CNT_W'(wr_done);
                        pre_snp_reg <= snp_out_reg - BOI_CNT_W'(snp_done);
                        state_reg <= BOI_ST_DRAIN;
                    end
                end
                BOI_ST_DRAIN: begin
                    // Count down completions; later traffic may overtake
                    if (rd_done && pre_rd_reg != BOI_CNT_RST) begin
                        pre_rd_reg <= pre_rd_reg - 1'b1;
                    end
                    if (wr_done && pre_wr_reg != BOI_CNT_RST) begin
                        pre_wr_reg <= pre_wr_reg - 1'b1;
                    end
                    if (snp_done && pre_snp_reg != BOI_CNT_RST) begin
                        pre_snp_reg <= pre_snp_reg - 1'b1;
                    end
                    if (drained) begin
                        r_done_reg <= 1'b0;
                        b_done_reg <= 1'b0;
                        state_reg <= BOI_ST_RESP;
                    end
                end
                BOI_ST_RESP: begin
                    // Both halves answered before the next pair starts
                    r_done_reg <= r_done_reg || r_ins;
                    b_done_reg <= b_done_reg || b_ins;
                    if ((r_done_reg || r_ins) && (b_done_reg || b_ins)) begin
                        state_reg <= BOI_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= BOI_ST_IDLE;
                end
            endcase
        end
    end

    // Upstream read data slot
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r_valid_reg <= 1'b0;
            s_r_id <= '0;
            s_r_data <= '0;
            s_r_last <= 1'b0;
        end else if (r_ins) begin
            // Barrier read answer: single beat, zero data
            s_r_valid_reg <= 1'b1;
            s_r_id <= rbar_id_reg;
            s_r_data <= '0;
            s_r_last <= 1'b1;
        end else if (r_load) begin
            s_r_valid_reg <= 1'b1;
            s_r_id <= m_r_id;
            s_r_data <= m_r_data;
            s_r_last <= m_r_last;
        end else if (s_r_ready) begin
            s_r_valid_reg <= 1'b0;
        end
    end

    // Upstream write response slot
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_b_valid_reg <= 1'b0;
            s_b_id <= '0;
        end else if (b_ins) begin
            s_b_valid_reg <= 1'b1;
            s_b_id <= wbar_mem[wq_rd_reg];
        end else if (b_load) begin
            s_b_valid_reg <= 1'b1;
            s_b_id <= m_b_id;
        end else if (s_b_ready) begin
            s_b_valid_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: logic/boi_pkg.sv
package boi_pkg;
    // Write barriers the slave port absorbs without blocking write traffic
    localparam int unsigned BOI_BAR_MAX = 256;
    // Pointer width of the write barrier queue
    localparam int unsigned BOI_PTR_W = 8;
    // Width of the outstanding transaction and snoop counters
    localparam int unsigned BOI_CNT_W = 16;
    // Counter reset value
    localparam logic [15:0] BOI_CNT_RST = 16'h0000;
    // Barrier engine states, one-hot
    typedef enum logic [3:0] {
        BOI_ST_IDLE  = 4'b0001, // No read barrier held
        BOI_ST_PAIR  = 4'b0010, // Read barrier held, waiting for write half
        BOI_ST_DRAIN = 4'b0100, // Waiting for pre-barrier traffic and snoops
        BOI_ST_RESP  = 4'b1000  // Returning both barrier responses
    } boi_state_t;
endpackage

// file: bench/boi_barrier_port_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port checker for the barrier engine
module boi_barrier_port_props #(
    parameter int unsigned ID_W = 4,
    parameter int unsigned ADDR_W = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic s_ar_valid,
    input wire logic s_ar_ready,
    input wire logic [ID_W-1:0] s_ar_id,
    input wire logic s_ar_bar,
    input wire logic s_aw_valid,
    input wire logic s_aw_ready,
    input wire logic s_aw_bar,
    input wire logic [ADDR_W-1:0] s_aw_addr,
    input wire logic m_aw_valid,
    input wire logic [ADDR_W-1:0] m_aw_addr,
    input wire logic s_r_valid,
    input wire logic s_r_ready,
    input wire logic [ID_W-1:0] s_r_id,
    input wire logic m_ar_valid,
    input wire logic m_ar_ready,
    input wire logic [ID_W-1:0] m_ar_id,
    input wire logic m_r_valid,
    input wire logic m_r_ready,
    input wire logic m_r_last,
    input wire logic cr_valid,
    input wire logic cr_ready,
    input wire logic bar_busy
);
    logic [15:0] rd_out_reg; // Downstream reads not yet answered
    logic [15:0] wbar_reg; // Write barriers that may still be queued
    logic busy_reg; // Engine busy one cycle ago
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Count open reads and queued barriers; a finished pair frees one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_out_reg <= 16'h0000;
            wbar_reg <= 16'h0000;
            busy_reg <= 1'b0;
        end else begin
            rd_out_reg <= rd_out_reg + 16'(m_ar_valid && m_ar_ready)
                - 16'(m_r_valid && m_r_ready && m_r_last);
            wbar_reg <= wbar_reg + 16'(s_aw_valid && s_aw_ready && s_aw_bar)
                - 16'(busy_reg && !bar_busy);
            busy_reg <= bar_busy;
        end
    end
    a_ar_fwd_next: assert property (
        s_ar_valid && s_ar_ready && !s_ar_bar |=> m_ar_valid && m_ar_id == $past(s_ar_id))
        else $error("read not forwarded next cycle");
    a_aw_fwd_next: assert property (
        s_aw_valid && s_aw_ready && !s_aw_bar |=> m_aw_valid && m_aw_addr == $past(s_aw_addr))
        else $error("write not forwarded next cycle");
    a_bar_held_local: assert property (
        s_ar_valid && s_ar_ready && s_ar_bar |=> (bar_busy && s_ar_ready == 1'b0) [*3])
        else $error("read barrier not held");
    a_busy_stall: assert property (bar_busy |-> !s_ar_ready)
        else $error("read channel open while barrier held");
    a_m_ar_hold: assert property (
        m_ar_valid && !m_ar_ready |=> m_ar_valid && $stable(m_ar_id))
        else $error("downstream read dropped early");
    a_wbar_open: assert property (
        s_aw_valid && s_aw_bar && wbar_reg < 16'h0100 |-> s_aw_ready)
        else $error("write barrier refused below capacity");
    a_snoop_open: assert property (cr_valid |-> cr_ready)
        else $error("snoop response stalled");
    a_drain_first: assert property (
        busy_reg && !bar_busy |-> rd_out_reg == 16'h0000 && !m_ar_valid)
        else $error("barrier done with reads open");
    a_r_hold: assert property (
        s_r_valid && !s_r_ready |=> s_r_valid && $stable(s_r_id))
        else $error("read answer dropped early");
    c_pair_done: cover property (busy_reg && !bar_busy);
    c_wbar_full: cover property (wbar_reg == 16'h0100);
    c_r_stall: cover property (s_r_valid && !s_r_ready);
endmodule
`default_nettype wire

// file: bench/boi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// Downstream slave: random accept, in-order answers at random pace
module boi_slave_model #(
    parameter int unsigned ID_W = 4,
    parameter int unsigned ADDR_W = 32,
    parameter int unsigned DATA_W = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic m_ar_valid,
    output logic m_ar_ready,
    input wire logic [ID_W-1:0] m_ar_id,
    input wire logic [ADDR_W-1:0] m_ar_addr,
    input wire logic m_aw_valid,
    output logic m_aw_ready,
    input wire logic [ID_W-1:0] m_aw_id,
    output logic m_r_valid,
    input wire logic m_r_ready,
    output logic [ID_W-1:0] m_r_id,
    output logic [DATA_W-1:0] m_r_data,
    output logic m_r_last,
    output logic m_b_valid,
    input wire logic m_b_ready,
    output logic [ID_W-1:0] m_b_id
);
    logic [ID_W+ADDR_W-1:0] rd_q[$]; // Accepted reads, id and address
    logic [ID_W-1:0] wr_q[$]; // Accepted write ids
    logic [ID_W+ADDR_W-1:0] rd_e; // Read being answered
    // Accept, queue and answer; a beat holds until taken
    always @(posedge clk_sys) begin
        if (rst) begin
            rd_q.delete();
            wr_q.delete();
            m_ar_ready <= 1'b0;
            m_aw_ready <= 1'b0;
            m_r_valid <= 1'b0;
            m_b_valid <= 1'b0;
        end else begin
            m_ar_ready <= ($urandom_range(3) != 0);
            m_aw_ready <= ($urandom_range(3) != 0);
            if (m_ar_valid && m_ar_ready) begin
                rd_q.push_back({m_ar_id, m_ar_addr});
            end
            if (m_aw_valid && m_aw_ready) begin
                wr_q.push_back(m_aw_id);
            end
            if (m_r_valid && !m_r_ready) begin
                // Beat waits
            end else if (rd_q.size() > 0 && $urandom_range(2) != 0) begin
                rd_e = rd_q.pop_front();
                m_r_valid <= 1'b1;
                m_r_id <= rd_e[ADDR_W+:ID_W];
                m_r_data <= DATA_W'(rd_e[ADDR_W-1:0] + 1'b1);
                m_r_last <= 1'b1;
            end else begin
                // Idle lines flip so stale values never look current
                m_r_valid <= 1'b0;
                m_r_id <= ~m_r_id;
                m_r_data <= ~m_r_data;
                m_r_last <= ~m_r_last;
            end
            if (m_b_valid && !m_b_ready) begin
                // Response waits
            end else if (wr_q.size() > 0 && $urandom_range(2) != 0) begin
                m_b_valid <= 1'b1;
                m_b_id <= wr_q.pop_front();
            end else begin
                m_b_valid <= 1'b0;
                m_b_id <= ~m_b_id;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/boi_barrier_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Bench: upstream master, snoop source and reference queues
module boi_barrier_port_tb_top
    import boi_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic s_ar_valid = 1'b0, s_ar_bar = 1'b0, s_aw_valid = 1'b0, s_aw_bar = 1'b0;
    logic s_r_ready = 1'b1, s_b_ready = 1'b1, snp_issue = 1'b0, cr_valid = 1'b0;
    logic [9:0] s_ar_id = 10'h000, s_aw_id = 10'h000;
    logic [31:0] s_ar_addr = 32'h0000_0000, s_aw_addr = 32'h0000_0000;
    logic s_ar_ready, s_aw_ready, s_r_valid, s_r_last, s_b_valid, cr_ready, bar_busy;
    logic m_ar_valid, m_ar_ready, m_aw_valid, m_aw_ready, m_r_valid, m_r_ready, m_r_last;
    logic m_b_valid, m_b_ready;
    logic [9:0] s_r_id, s_b_id, m_ar_id, m_aw_id, m_r_id, m_b_id;
    logic [31:0] s_r_data, m_ar_addr, m_aw_addr, m_r_data;
    logic [41:0] exp_r[$]; // Normal reads: id and data
    logic [9:0] exp_rb[$], exp_b[$], exp_bb[$]; // Barrier reads, writes, barrier writes
    logic [41:0] er;
    int error_cnt = 0, n_compared = 0, snp_open = 0, n_awbar = 0, n_rbar = 0, seed_v, i;
    boi_barrier_port #(.ID_W(10)) boi_barrier_port_i (.*);
    boi_slave_model #(.ID_W(10)) boi_slave_model_i (.*);
    always #4 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Read request held until accepted; valid left high for back-to-back use
    task automatic send_ar(input logic [9:0] id, input logic [31:0] addr, input logic bar);
        s_ar_valid <= 1'b1;
        s_ar_id <= id;
        s_ar_addr <= addr;
        s_ar_bar <= bar;
        do @(posedge clk_sys); while (s_ar_ready !== 1'b1);
        if (bar) exp_rb.push_back(id);
        else exp_r.push_back({id, addr + 32'h0000_0001});
    endtask
    task automatic send_aw(input logic [9:0] id, input logic [31:0] addr, input logic bar);
        s_aw_valid <= 1'b1;
        s_aw_id <= id;
        s_aw_addr <= addr;
        s_aw_bar <= bar;
        do @(posedge clk_sys); while (s_aw_ready !== 1'b1);
        if (bar) exp_bb.push_back(id);
        else exp_b.push_back(id);
        n_awbar += int'(bar);
    endtask
    task automatic wait_quiet();
        int n;
        n = 0;
        while (exp_r.size() + exp_rb.size() + exp_b.size() + exp_bb.size() != 0 && n < 9000) begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(n < 9000), 32'h0000_0001);
    endtask
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Upstream stalls on answers
    always @(posedge clk_sys) begin
        s_r_ready <= ($urandom_range(3) != 0);
        s_b_ready <= ($urandom_range(3) != 0);
    end
    // Reference model: compare every upstream answer
    always @(posedge clk_sys) begin
        if (!rst && s_r_valid === 1'b1 && s_r_ready) begin
            check(32'(s_r_last), 32'h0000_0001);
            if (s_r_id[9]) begin
                n_rbar++;
                check(32'(n_awbar >= n_rbar), 32'h0000_0001);
                check(32'(snp_open), 32'h0000_0000);
                check({22'h0, s_r_id}, {22'h0, exp_rb.pop_front()});
                check(s_r_data, 32'h0000_0000);
            end else begin
                er = exp_r.pop_front();
                check({22'h0, s_r_id}, {22'h0, er[41:32]});
                check(s_r_data, er[31:0]);
            end
        end
        if (!rst && s_b_valid === 1'b1 && s_b_ready) begin
            if (s_b_id[9]) check({22'h0, s_b_id}, {22'h0, exp_bb.pop_front()});
            else check({22'h0, s_b_id}, {22'h0, exp_b.pop_front()});
        end
        snp_open = snp_open + int'(snp_issue) - int'(cr_valid);
    end
    initial begin
        seed_v = $urandom(66);
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        fork
            begin
                for (int k = 0; k < 24; k++) send_ar(10'($urandom_range(511)), $urandom(), 1'b0);
                s_ar_valid <= 1'b0;
            end
            begin
                for (int k = 0; k < 24; k++) send_aw(10'($urandom_range(511)), $urandom(), 1'b0);
                s_aw_valid <= 1'b0;
            end
        join
        wait_quiet();
        fork
            begin
                snp_issue <= 1'b1;
                @(posedge clk_sys);
                snp_issue <= 1'b0;
                repeat (100) @(posedge clk_sys);
                cr_valid <= 1'b1;
                @(posedge clk_sys);
                cr_valid <= 1'b0;
            end
            begin
                send_ar(10'h001, $urandom(), 1'b0);
                send_ar(10'h3FF, 32'h0000_0000, 1'b1);
                s_ar_valid <= 1'b0;
            end
            begin
                for (int k = 0; k < 8; k++) send_aw(10'(k), $urandom(), 1'b0);
                send_aw(10'h3FF, 32'h0000_0000, 1'b1);
                s_aw_valid <= 1'b0;
            end
        join
        wait_quiet();
        for (i = 0; i < BOI_BAR_MAX; i++) send_aw(10'(512 + i), $urandom(), 1'b1);
        for (i = 0; i < 4; i++) send_aw(10'(i), $urandom(), 1'b0);
        s_aw_valid <= 1'b0;
        for (i = 0; i < BOI_BAR_MAX; i++) begin
            send_ar(10'($urandom_range(511)), $urandom(), 1'b0);
            send_ar(10'(512 + i), 32'h0000_0000, 1'b1);
        end
        s_ar_valid <= 1'b0;
        wait_quiet();
        give_verdict();
    end
    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk_sys);
        error_cnt++;
        give_verdict();
    end
endmodule
bind boi_barrier_port boi_barrier_port_props #(.ID_W(ID_W), .ADDR_W(ADDR_W)) boi_barrier_port_props_i (.*);
`default_nettype wire
